// ==== rtl/link_ctl_pkg.sv ====
// Constants for the debug link physical-layer control block
// Overview of operation
// - With the inter-byte gap enabled, two idle characters separate consecutive bytes of a multi-byte repeated-load answer.
// - The first byte of such an answer waits the normal turnaround guard, not the inter-byte gap.
// - With parity checking off, the parity bit is ignored and no parity error is raised.
// - With time-out watching on, an access-layer answer must come within 65536 cycles or a time-out is flagged.
// - With time-out watching off, no time-out is ever declared.
// - With acknowledge signatures off, no acknowledge signature is sent after an access.
// - Each receive-to-transmit turnaround waits 128 cycles at code 0, halving per step down to 2 at code 6.
// - Guard code 7 inserts no extra idle bits at turnaround.
// - The control register reads 0x00 after reset.
package link_ctl_pkg;
   localparam logic [1:0]  CTRL_OFFSET      = 2'h2;
   localparam logic [7:0]  CTRL_RESET       = 8'h00;
   localparam logic [7:0]  CTRL_WMASK       = 8'hBF;
   localparam int          GAP_EN_BIT       = 7;
   localparam int          PAR_OFF_BIT      = 5;
   localparam int          TMO_OFF_BIT      = 4;
   localparam int          ACK_OFF_BIT      = 3;
   localparam int          GUARD_LSB        = 0;
   localparam int          GUARD_W          = 3;
   localparam logic [2:0]  GUARD_NONE       = 3'h7;
   localparam int          GUARD_MAX_CYC    = 128;
   localparam int          IDLE_CHAR_BITS   = 12;
   localparam int          GAP_CHARS        = 2;
   localparam int          GAP_BITS         = GAP_CHARS * IDLE_CHAR_BITS;
   localparam int          TIMEOUT_CYC      = 65536;
   localparam logic [31:0] UNMAPPED_RDATA   = 32'h0000_0000;
endpackage : link_ctl_pkg

// ==== rtl/guard_timer.sv ====
// Down-counter that times turnaround guard and inter-byte gaps
`timescale 1ns/1ps
`default_nettype none
module guard_timer #(
   parameter int CNT_W = 8
) (
   input  wire logic             sys_clk, // Clock
   input  wire logic             rst,     // Sync reset
   input  wire logic             load,    // Start a wait
   input  wire logic [CNT_W-1:0] count,   // Cycles to wait
   output logic                  busy     // Wait in progress
);
   typedef struct packed {
      logic [CNT_W-1:0] cnt;
   } tmr_s;
   tmr_s cur_ff;
   tmr_s nxt_ff;
   always_comb begin
      nxt_ff = cur_ff;
      if (load) begin
         nxt_ff.cnt = count;
      end else if (cur_ff.cnt != '0) begin
         nxt_ff.cnt = cur_ff.cnt - 1'b1;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cur_ff <= '0;
      end else begin
         cur_ff <= nxt_ff;
      end
   end
   assign busy = (cur_ff.cnt != '0);
endmodule : guard_timer
`default_nettype wire

// ==== rtl/timeout_watch.sv ====
// Watchdog on the access-layer response time
`timescale 1ns/1ps
`default_nettype none
module timeout_watch #(
   parameter int LIMIT = 65536
) (
   input  wire logic sys_clk,  // Clock
   input  wire logic rst,      // Sync reset
   input  wire logic enable,   // Watching allowed
   input  wire logic waiting,  // Request outstanding
   output logic      expired   // One-cycle time-out pulse
);
   localparam int W = $clog2(LIMIT + 1);
   typedef struct packed {
      logic [W-1:0] cnt;
      logic         hit;
      logic         done;
   } wd_s;
   wd_s cur_ff;
   wd_s nxt_ff;
   always_comb begin
      nxt_ff     = cur_ff;
      nxt_ff.hit = 1'b0;
      if (!enable || !waiting) begin
         nxt_ff.cnt  = '0;
         nxt_ff.done = 1'b0;
      end else if (!cur_ff.done) begin
         if (cur_ff.cnt == W'(LIMIT - 1)) begin
            nxt_ff.hit  = 1'b1;
            nxt_ff.done = 1'b1;
         end else begin
            nxt_ff.cnt = cur_ff.cnt + 1'b1;
         end
      end
   end
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cur_ff <= '0;
      end else begin
         cur_ff <= nxt_ff;
      end
   end
   assign expired = cur_ff.hit;
endmodule : timeout_watch
`default_nettype wire

// ==== rtl/debug_link_phy_control.sv ====
// Control register and transmit pacing of the debug link physical layer
//
// Our own choice: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module debug_link_phy_control
   import link_ctl_pkg::*;
#(
   parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
   input  wire logic        sys_clk,          // 100 MHz clock
   input  wire logic        rst,              // Sync reset, active high
   input  wire logic [1:0]  avs_address,      // Word address
   input  wire logic        avs_read,         // Read request
   input  wire logic        avs_write,        // Write request
   input  wire logic [31:0] avs_writedata,    // Write data
   input  wire logic [3:0]  avs_byteenable,   // Byte lanes
   output logic [31:0]      avs_readdata,     // Read data
   output logic             avs_waitrequest,  // Stall
   input  wire logic        rx_char_valid,    // Received char pulse
   input  wire logic        rx_parity_bad,    // Parity mismatch of char
   output logic             parity_error,     // Parity error pulse
   input  wire logic        turnaround_req,   // Rx to tx switch pulse
   input  wire logic        tx_byte_req,      // Byte ready to send
   input  wire logic        tx_is_ack,        // Byte is an ack signature
   input  wire logic        tx_multi_load,    // Part of repeated load
   output logic             tx_byte_go,       // Send byte now
   output logic             tx_byte_drop,     // Signature suppressed
   input  wire logic        acc_req_pending,  // Awaiting access layer
   output logic             acc_timeout,      // Time-out pulse
   output logic [7:0]       phy_link_control  // Register value
);
   typedef enum logic [2:0] {
      TX_IDLE  = 3'b001,
      TX_GUARD = 3'b010,
      TX_READY = 3'b100
   } tx_state_e;
   typedef struct packed {
      logic [7:0]  ctrl;
      tx_state_e   st;
      logic        first;
      logic        ack;
      logic        rd_ack;
      logic [31:0] rdata;
      logic        perr;
   } ctl_s;
   ctl_s cur_ff;
   ctl_s nxt_ff;
   logic       tmr_load;
   logic [7:0] tmr_count;
   logic       tmr_busy;
   logic       tmo_pulse;
   logic [2:0] gsel;

   // Guard code to cycles: 128 >> code, code 7 means no guard
   function automatic logic [7:0] guard_cycles(input logic [2:0] sel);
      logic [7:0] v;
      v = 8'(GUARD_MAX_CYC) >> sel;
      if (sel == GUARD_NONE) begin
         v = 8'h00;
      end
      return v;
   endfunction : guard_cycles

   assign gsel = cur_ff.ctrl[GUARD_LSB +: GUARD_W];

   always_comb begin
      nxt_ff        = cur_ff;
      nxt_ff.ack    = 1'b0;
      nxt_ff.rd_ack = 1'b0;
      nxt_ff.perr   = 1'b0;
      tmr_load      = 1'b0;
      tmr_count     = 8'h00;
      tx_byte_go    = 1'b0;
      tx_byte_drop  = 1'b0;
      // One wait state on every access keeps read data registered
      if ((avs_read || avs_write) && !cur_ff.ack) begin
         nxt_ff.ack = 1'b1;
         if (avs_address == CTRL_OFFSET) begin
            nxt_ff.rdata = {24'h000000, cur_ff.ctrl};
         end else begin
            nxt_ff.rdata = UNMAPPED_RDATA;
         end
      end
      // Write lands only at the edge that completes the transfer
      if (avs_write && cur_ff.ack && avs_address == CTRL_OFFSET
          && avs_byteenable[0]) begin
         nxt_ff.ctrl = avs_writedata[7:0] & CTRL_WMASK;
      end
      // Parity errors only count while checking is on
      if (rx_char_valid && rx_parity_bad && !cur_ff.ctrl[PAR_OFF_BIT]) begin
         nxt_ff.perr = 1'b1;
      end
      case (cur_ff.st)
         TX_IDLE: begin
            if (turnaround_req) begin
               tmr_load    = 1'b1;
               tmr_count   = guard_cycles(gsel);
               nxt_ff.st   = TX_GUARD;
               nxt_ff.first = 1'b1;
            end
         end
         TX_GUARD: begin
            if (!tmr_busy) begin
               nxt_ff.st = TX_READY;
            end
         end
         TX_READY: begin
            if (turnaround_req) begin
               tmr_load     = 1'b1;
               tmr_count    = guard_cycles(gsel);
               nxt_ff.st    = TX_GUARD;
               nxt_ff.first = 1'b1;
            end else if (tx_byte_req) begin
               if (tx_is_ack && cur_ff.ctrl[ACK_OFF_BIT]) begin
                  tx_byte_drop = 1'b1;
               end else begin
                  tx_byte_go   = 1'b1;
                  nxt_ff.first = 1'b0;
                  // Later bytes of a repeated load wait two idle chars
                  if (tx_multi_load && cur_ff.ctrl[GAP_EN_BIT]) begin
                     tmr_load  = 1'b1;
                     tmr_count = 8'(GAP_BITS);
                     nxt_ff.st = TX_GUARD;
                  end
               end
            end
         end
         default: begin
            nxt_ff.st = TX_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cur_ff       <= '0;
         cur_ff.ctrl  <= CTRL_RESET;
         cur_ff.st    <= TX_IDLE;
      end else begin
         cur_ff <= nxt_ff;
      end
   end

   guard_timer #(
      .CNT_W (8)
   ) u_guard (
      .sys_clk (sys_clk),
      .rst     (rst),
      .load    (tmr_load),
      .count   (tmr_count),
      .busy    (tmr_busy)
   );

   timeout_watch #(
      .LIMIT (TIMEOUT_CYCLES)
   ) u_watch (
      .sys_clk (sys_clk),
      .rst     (rst),
      .enable  (!cur_ff.ctrl[TMO_OFF_BIT]),
      .waiting (acc_req_pending),
      .expired (tmo_pulse)
   );

   assign avs_waitrequest  = (avs_read || avs_write) && !cur_ff.ack;
   assign avs_readdata     = cur_ff.rdata;
   assign parity_error     = cur_ff.perr;
   assign acc_timeout      = tmo_pulse;
   assign phy_link_control = cur_ff.ctrl;
endmodule : debug_link_phy_control
`default_nettype wire

// ==== tb/link_ctl_chk.sv ====
// Concurrent checks on the debug link control block
`timescale 1ns/1ps
`default_nettype none
module link_ctl_chk (
   input wire logic       sys_clk,         // Clock
   input wire logic       rst,             // Reset
   input wire logic       rx_char_valid,   // Char in
   input wire logic       rx_parity_bad,   // Bad parity
   input wire logic       parity_error,    // Error out
   input wire logic       turnaround_req,  // Turnaround
   input wire logic       tx_byte_req,     // Tx request
   input wire logic       tx_is_ack,       // Ack byte
   input wire logic       tx_byte_go,      // Sent
   input wire logic       tx_byte_drop,    // Dropped
   input wire logic       acc_timeout,     // Time-out
   input wire logic [7:0] phy_link_control // Register
);
   logic [7:0] age_ff;
   logic [7:0] guard;
   logic       bad_c;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // Saturates so a long idle never wraps into a false short guard
   always_ff @(posedge sys_clk) begin
      if (rst || turnaround_req) age_ff <= 8'h00;
      else if (age_ff != 8'hFF) age_ff <= age_ff + 8'h01;
   end
   assign guard = (phy_link_control[2:0] == 3'h7) ? 8'h00
                : 8'h80 >> phy_link_control[2:0];
   assign bad_c = rx_char_valid & rx_parity_bad & ~phy_link_control[5];
   sequence s_bad;
      bad_c;
   endsequence
   property p_par_hit; s_bad |=> parity_error; endproperty
   a_par_hit: assert property (p_par_hit) else $error("parity miss");
   property p_par_off; parity_error |-> $past(bad_c); endproperty
   a_par_off: assert property (p_par_off) else $error("parity flag");
   property p_guard; tx_byte_go |-> 9'(age_ff) + 9'h001 >= 9'(guard);
   endproperty
   a_guard: assert property (p_guard) else $error("guard short");
   property p_drop;
      tx_byte_drop |-> tx_byte_req && tx_is_ack && phy_link_control[3];
   endproperty
   a_drop: assert property (p_drop) else $error("bad drop");
   property p_ack_go;
      tx_byte_go |-> tx_byte_req && !(tx_is_ack && phy_link_control[3]);
   endproperty
   a_ack_go: assert property (p_ack_go) else $error("ack sent");
   property p_tmo_off; acc_timeout |-> !$past(phy_link_control[4]);
   endproperty
   a_tmo_off: assert property (p_tmo_off) else $error("time-out");
   property p_bit6; phy_link_control[6] == 1'b0; endproperty
   a_bit6: assert property (p_bit6) else $error("bit 6 set");
   property p_rst; $fell(rst) |-> phy_link_control == 8'h00; endproperty
   a_rst: assert property (p_rst) else $error("reset value");
endmodule : link_ctl_chk
bind debug_link_phy_control link_ctl_chk i_chk (.*);
`default_nettype wire

// ==== tb/link_far_model.sv ====
// Behavioural debugger adapter on the wire side of the link
`timescale 1ns/1ps
`default_nettype none
module link_far_model (
   input wire logic sys_clk,        // Clock
   input wire logic tx_byte_go,     // Byte sent
   input wire logic tx_byte_drop,   // Ack dropped
   output var logic turnaround_req, // Turnaround
   output var logic tx_byte_req,    // Byte waiting
   output var logic tx_is_ack,      // Ack byte
   output var logic tx_multi_load   // Repeated load
);
   initial begin
      {turnaround_req, tx_byte_req, tx_is_ack, tx_multi_load} = 4'h0;
   end
   task automatic turn();
      turnaround_req <= 1'b1;
      @(posedge sys_clk);
      turnaround_req <= 1'b0;
      @(posedge sys_clk);
   endtask : turn
   // Acks are only turned off by a host that knows the bus latency
   task automatic send(input logic ack, input logic multi, input int lag,
                       output int n, output logic g);
      repeat (lag) @(posedge sys_clk);
      {tx_byte_req, tx_is_ack, tx_multi_load} <= {1'b1, ack, multi};
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
         g = tx_byte_go;
      end while (!(tx_byte_go || tx_byte_drop) && n < 400);
   endtask : send
   task automatic stop();
      tx_byte_req <= 1'b0;
   endtask : stop
endmodule : link_far_model
`default_nettype wire

// ==== tb/debug_link_phy_control_tb_top.sv ====
// Self-checking bench for the debug link control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; \
   $display("CHECK FAILED at %0t: mismatch", $time); end end
module debug_link_phy_control_tb_top;
   import link_ctl_pkg::*;
   localparam int TMO = 64;
   logic        sys_clk, rst, avs_read, avs_write, avs_waitrequest;
   logic        rx_char_valid, rx_parity_bad, parity_error, acc_req_pending;
   logic        turnaround_req, tx_byte_req, tx_is_ack, tx_multi_load;
   logic        tx_byte_go, tx_byte_drop, acc_timeout, g;
   logic [1:0]  avs_address;
   logic [3:0]  avs_byteenable;
   logic [7:0]  phy_link_control;
   logic [31:0] avs_writedata, avs_readdata, q;
   int          n_mismatch = 0;
   int          checks = 0;
   int          n;
   int          n1;
   debug_link_phy_control #(.TIMEOUT_CYCLES(TMO)) i_dut (.*);
   link_far_model i_far (.*);
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   task automatic bus(input logic wr, input logic [1:0] a,
                      input logic [7:0] d);
      {avs_address, avs_writedata} <= {a, 24'h000000, d};
      {avs_write, avs_read} <= {wr, !wr};
      do begin
         @(posedge sys_clk);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      {avs_write, avs_read} <= 2'b00;
      @(posedge sys_clk);
   endtask : bus
   task automatic t_reg();
      bus(1'b0, 2'h2, 8'h00);
      `CHK(q, 32'h00000000)
      bus(1'b1, 2'h2, 8'hFF);
      bus(1'b1, 2'h0, 8'h00);
      bus(1'b0, 2'h2, 8'h00);
      `CHK(q, 32'h000000BF)
      bus(1'b0, 2'h0, 8'h00);
      `CHK(q, 32'h00000000)
   endtask : t_reg
   task automatic t_guard();
      for (int c = 0; c < 8; c++) begin
         bus(1'b1, 2'h2, 8'(c));
         i_far.turn();
         i_far.send(1'b0, 1'b0, 0, n, g);
         i_far.stop();
         n1 = (c == 7) ? 0 : GUARD_MAX_CYC >> c;
         `CHK({g, n >= n1 && n <= n1 + 6}, 2'h3)
      end
   endtask : t_guard
   task automatic t_gap();
      for (int b = 0; b < 2; b++) begin
         bus(1'b1, 2'h2, {b[0], 7'h06});
         i_far.turn();
         i_far.send(1'b0, 1'b1, 0, n1, g);
         i_far.send(1'b0, 1'b1, 0, n, g);
         i_far.stop();
         `CHK(n1 <= 8, 1'b1)
         `CHK(b ? (n >= GAP_BITS && n <= GAP_BITS + 6) : n <= 3, 1'b1)
      end
   endtask : t_gap
   task automatic t_ack();
      for (int b = 0; b < 2; b++) begin
         bus(1'b1, 2'h2, {4'h0, b[0], 3'h7});
         i_far.turn();
         i_far.send(1'b1, 1'b0, 2, n, g);
         i_far.stop();
         `CHK({g, n < 20}, {!b[0], 1'b1})
      end
   endtask : t_ack
   task automatic t_par();
      for (int b = 0; b < 2; b++) begin
         bus(1'b1, 2'h2, {2'h0, b[0], 5'h00});
         {rx_char_valid, rx_parity_bad} <= 2'b11;
         @(posedge sys_clk);
         {rx_char_valid, rx_parity_bad} <= 2'b00;
         @(negedge sys_clk);
         `CHK(parity_error, !b[0])
         @(posedge sys_clk);
      end
   endtask : t_par
   task automatic t_tmo();
      for (int b = 0; b < 2; b++) begin
         bus(1'b1, 2'h2, {3'h0, b[0], 4'h0});
         acc_req_pending <= 1'b1;
         n = 0;
         do begin
            @(negedge sys_clk);
            n++;
         end while (acc_timeout !== 1'b1 && n < 150);
         `CHK(b ? n == 150 : (n >= TMO && n <= TMO + 4), 1'b1)
         @(posedge sys_clk);
         acc_req_pending <= 1'b0;
         @(posedge sys_clk);
      end
   endtask : t_tmo
   task automatic close_out();
      if (n_mismatch == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : close_out
   initial begin
      {rst, avs_read, avs_write, rx_char_valid, rx_parity_bad} = 5'h10;
      {acc_req_pending, avs_address, avs_writedata} = 35'h0;
      avs_byteenable = 4'h1;
      repeat (20) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      t_reg();
      t_guard();
      t_gap();
      t_ack();
      t_par();
      t_tmo();
      close_out();
   end
   // Whole run is well under a thousand cycles; this only catches a hang
   initial begin
      #100000;
      n_mismatch++;
      close_out();
   end
endmodule : debug_link_phy_control_tb_top
`default_nettype wire
